// *** inc/eprom_host_pkg.sv ***
// Constants and types for the byte-wide memory programmer and reader
`default_nettype none
package eprom_host_pkg;
    // ****************************************************************
    // Array shape
    // ****************************************************************
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int TMR_W = 16;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;

    // ****************************************************************
    // Timing, in ns, and derived clock counts
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_PULSE_NS = 100000;
    localparam int T_PULSE_MIN_NS = 95000;
    localparam int T_PULSE_MAX_NS = 105000;
    localparam int T_SETUP_NS = 2000;
    localparam int T_HOLD_NS = 2000;
    localparam int T_ACCESS_NS = 250;
    localparam int SYNC_STAGES = 2;
    localparam int PULSE_CYC = T_PULSE_NS / CLK_PERIOD_NS;
    localparam int SETUP_CYC =
        (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC =
        (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC =
        (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int MAX_PULSES = 10;

    // ****************************************************************
    // Commands and states
    // ****************************************************************
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_SIGNATURE = 2'h2,
        OP_CHECK = 2'h3
    } op_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_PULSE = 3'b010,
        ST_HOLD = 3'b011,
        ST_TURN = 3'b100,
        ST_ACCESS = 3'b101
    } state_type;
endpackage : eprom_host_pkg
`default_nettype wire

// *** inc/timer_if.sv ***
// Start and done signals between the sequencer and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
    logic start;
    logic [eprom_host_pkg::TMR_W-1:0] load;
    logic done;
    modport ctrl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface : timer_if
`default_nettype wire

// *** rtl/interval_timer.sv ***
// Down counter giving a one-cycle done pulse after a loaded interval
`timescale 1ns/1ps
`default_nettype none
module interval_timer (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    timer_if.tmr tif // Start, load and done
);
    logic [eprom_host_pkg::TMR_W-1:0] count_q;
    logic run_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= '0;
            run_q <= 1'b0;
            tif.done <= 1'b0;
        end else begin
            tif.done <= 1'b0;
            if (tif.start) begin
                count_q <= tif.load;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (count_q <= 16'h0002) begin
                    run_q <= 1'b0;
                    tif.done <= 1'b1;
                end else begin
                    count_q <= count_q - 16'h0001;
                end
            end
        end
    end
endmodule : interval_timer
`default_nettype wire

// *** rtl/eprom_host.sv ***
// Programmer and reader driving a 16K x 8 programmable memory by its pins
`timescale 1ns/1ps
`default_nettype none
module eprom_host #(
    parameter int PULSE_CYCLES = eprom_host_pkg::PULSE_CYC
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic cmd_valid, // Command offered
    output logic cmd_ready, // Command accepted when valid
    input wire eprom_host_pkg::op_type cmd_op, // Command kind
    input wire logic [13:0] cmd_addr, // Byte address
    input wire logic [7:0] cmd_data, // Byte to program or expect
    output logic resp_valid, // One-cycle answer pulse
    output logic [7:0] resp_data, // Byte read back
    output logic resp_fail, // Program or check failed
    output logic device_failed, // Sticky failure, blocks programming
    output logic [13:0] mem_addr, // Address pins
    output logic chip_on_n, // Chip enable pin
    output logic output_drv_n, // Output enable pin
    output logic prog_strobe_n, // Program pulse pin
    output logic vpp_raise, // Request raised programming supply
    output logic id_hv_on, // Force identifier voltage on address
    input wire logic [7:0] byte_lines_in, // Data pins, sensed
    output logic [7:0] byte_lines_out, // Data pins, driven
    output logic byte_lines_oe // High while driving data pins
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    eprom_host_pkg::state_type state_q;
    eprom_host_pkg::op_type op_q;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [3:0] pulse_cnt_q;
    logic [15:0] wait_load;
    logic wait_start;
    logic take;
    logic match;
    logic prog_miss;
    logic retry;
    timer_if tif ();
    interval_timer u_timer (
        .clk(clk),
        .reset(reset),
        .tif(tif.tmr)
    );
    assign tif.start = wait_start;
    assign tif.load = wait_load;
    assign cmd_ready = (state_q == eprom_host_pkg::ST_IDLE);
    assign take = cmd_valid && cmd_ready;
    assign match = (sync2_q == byte_lines_out);
    assign prog_miss = op_q == eprom_host_pkg::OP_PROGRAM && !match;
    assign retry = prog_miss && pulse_cnt_q < 4'(eprom_host_pkg::MAX_PULSES);

    // ****************************************************************
    // Data pin synchroniser
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= byte_lines_in;
            sync2_q <= sync1_q;
        end
    end
    // ****************************************************************
    // Interval requests to the timer
    // ****************************************************************
    always_comb begin
        wait_start = 1'b0;
        wait_load = 16'(eprom_host_pkg::SETUP_CYC);
        case (state_q)
            eprom_host_pkg::ST_IDLE: begin
                if (take && cmd_op == eprom_host_pkg::OP_PROGRAM) begin
                    wait_start = !device_failed;
                end else if (take) begin
                    wait_start = 1'b1;
                    wait_load = 16'(eprom_host_pkg::ACCESS_CYC);
                end
            end
            eprom_host_pkg::ST_SETUP: begin
                wait_start = tif.done;
                wait_load = 16'(PULSE_CYCLES);
            end
            eprom_host_pkg::ST_PULSE: begin
                wait_start = tif.done;
                wait_load = 16'(eprom_host_pkg::HOLD_CYC);
            end
            eprom_host_pkg::ST_HOLD: begin
                wait_start = tif.done;
            end
            eprom_host_pkg::ST_TURN: begin
                wait_start = tif.done;
                wait_load = 16'(eprom_host_pkg::ACCESS_CYC);
            end
            eprom_host_pkg::ST_ACCESS: begin
                wait_start = tif.done && retry;
            end
            default: wait_start = 1'b0;
        endcase
    end
    // ****************************************************************
    // Sequencer and pin drive
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= eprom_host_pkg::ST_IDLE;
            op_q <= eprom_host_pkg::OP_READ;
            pulse_cnt_q <= '0;
            mem_addr <= '0;
            chip_on_n <= 1'b1;
            output_drv_n <= 1'b1;
            prog_strobe_n <= 1'b1;
            vpp_raise <= 1'b0;
            id_hv_on <= 1'b0;
            byte_lines_out <= eprom_host_pkg::ERASED_BYTE;
            byte_lines_oe <= 1'b0;
            resp_valid <= 1'b0;
            resp_data <= '0;
            resp_fail <= 1'b0;
            device_failed <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            case (state_q)
                eprom_host_pkg::ST_IDLE: begin
                    if (take) begin
                        op_q <= cmd_op;
                        byte_lines_out <= cmd_data;
                        pulse_cnt_q <= '0;
                        mem_addr <= cmd_addr;
                        if (cmd_op == eprom_host_pkg::OP_PROGRAM) begin
                            if (device_failed) begin
                                resp_valid <= 1'b1;
                                resp_fail <= 1'b1;
                            end else begin
                                vpp_raise <= 1'b1;
                                chip_on_n <= 1'b0;
                                byte_lines_oe <= 1'b1;
                                state_q <= eprom_host_pkg::ST_SETUP;
                            end
                        end else begin
                            if (cmd_op == eprom_host_pkg::OP_SIGNATURE) begin
                                id_hv_on <= 1'b1;
                                mem_addr <= 14'(cmd_addr[0]);
                            end
                            vpp_raise <= 1'b0;
                            chip_on_n <= 1'b0;
                            output_drv_n <= 1'b0;
                            state_q <= eprom_host_pkg::ST_ACCESS;
                        end
                    end
                end
                eprom_host_pkg::ST_SETUP: begin
                    if (tif.done) begin
                        prog_strobe_n <= 1'b0;
                        pulse_cnt_q <= pulse_cnt_q + 4'h1;
                        state_q <= eprom_host_pkg::ST_PULSE;
                    end
                end
                eprom_host_pkg::ST_PULSE: begin
                    if (tif.done) begin
                        prog_strobe_n <= 1'b1;
                        state_q <= eprom_host_pkg::ST_HOLD;
                    end
                end
                eprom_host_pkg::ST_HOLD: begin
                    if (tif.done) begin
                        byte_lines_oe <= 1'b0;
                        state_q <= eprom_host_pkg::ST_TURN;
                    end
                end
                eprom_host_pkg::ST_TURN: begin
                    if (tif.done) begin
                        output_drv_n <= 1'b0;
                        state_q <= eprom_host_pkg::ST_ACCESS;
                    end
                end
                eprom_host_pkg::ST_ACCESS: begin
                    if (tif.done) begin
                        output_drv_n <= 1'b1;
                        if (retry) begin
                            byte_lines_oe <= 1'b1;
                            state_q <= eprom_host_pkg::ST_SETUP;
                        end else begin
                            resp_valid <= 1'b1;
                            resp_data <= sync2_q;
                            resp_fail <= (op_q == eprom_host_pkg::OP_PROGRAM
                                || op_q == eprom_host_pkg::OP_CHECK) && !match;
                            if (prog_miss) begin
                                device_failed <= 1'b1;
                            end
                            chip_on_n <= 1'b1;
                            vpp_raise <= 1'b0;
                            id_hv_on <= 1'b0;
                            state_q <= eprom_host_pkg::ST_IDLE;
                        end
                    end
                end
                default: state_q <= eprom_host_pkg::ST_IDLE;
            endcase
        end
    end
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] low_len_q;
    always_ff @(posedge clk) begin
        if (reset || prog_strobe_n) begin
            low_len_q <= '0;
        end else begin
            low_len_q <= low_len_q + 16'h0001;
        end
    end
    property p_no_contention;
        !(byte_lines_oe && !output_drv_n);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("Data driven while memory outputs enabled");
    property p_prog_mode;
        !prog_strobe_n |-> vpp_raise && !chip_on_n && output_drv_n;
    endproperty
    a_prog_mode: assert property (p_prog_mode)
        else $error("Program pulse outside programming mode");
    property p_stable_under_pulse;
        !prog_strobe_n && $past(!prog_strobe_n) |->
            $stable(mem_addr) && $stable(byte_lines_out) && byte_lines_oe;
    endproperty
    a_stable_under_pulse: assert property (p_stable_under_pulse)
        else $error("Address or data moved during program pulse");
    property p_pulse_width;
        $rose(prog_strobe_n) |-> $past(low_len_q) == 16'(PULSE_CYCLES - 1);
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("Program pulse width wrong");
    property p_pulse_limit;
        pulse_cnt_q <= 4'(eprom_host_pkg::MAX_PULSES);
    endproperty
    a_pulse_limit: assert property (p_pulse_limit)
        else $error("More than ten pulses on one byte");
    property p_verify_follows;
        $rose(prog_strobe_n) |-> ##[400:410] !output_drv_n;
    endproperty
    a_verify_follows: assert property (p_verify_follows)
        else $error("No verify read after program pulse");
    property p_id_address;
        id_hv_on |-> mem_addr[13:1] == 13'h0000;
    endproperty
    a_id_address: assert property (p_id_address)
        else $error("Stray address bits in identifier read");
    property p_idle_deselect;
        state_q == eprom_host_pkg::ST_IDLE |-> output_drv_n && chip_on_n;
    endproperty
    a_idle_deselect: assert property (p_idle_deselect)
        else $error("Memory selected while idle");
    property p_read_level;
        take && cmd_op == eprom_host_pkg::OP_CHECK |=> !vpp_raise && !id_hv_on;
    endproperty
    a_read_level: assert property (p_read_level)
        else $error("Final check with supply raised");
    property p_fail_stops;
        resp_valid && resp_fail && op_q == eprom_host_pkg::OP_PROGRAM
            |-> device_failed;
    endproperty
    a_fail_stops: assert property (p_fail_stops)
        else $error("Program failure not latched");
endmodule : eprom_host
`default_nettype wire

// *** verif/mem_device_model.sv ***
// Behavioural model of the byte-wide programmable memory
`timescale 1ns/1ps
`default_nettype none
module mem_device_model #(
    parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h1e // Arbitrary value
) (
    input wire logic clk, // Bench clock, for line float and pin checks
    input wire logic [13:0] mem_addr, // Address pins
    input wire logic chip_on_n, // Chip enable
    input wire logic output_drv_n, // Output enable
    input wire logic prog_strobe_n, // Program pulse
    input wire logic vpp_raise, // Raised supply
    input wire logic id_hv_on, // Identifier voltage
    input wire logic [7:0] host_data, // Host data
    input wire logic host_oe, // Host drives data
    output logic [7:0] byte_lines // Resolved data pins
);
    // ****************************************
    // Storage and programming
    // ****************************************
    logic [7:0] mem [0:16383];
    int need [0:16383];
    int hits [0:16383];
    int pulses = 0;
    int violations = 0;
    time width_ns = 0;
    time t_fall = 0;
    time t_chg = 0;
    logic [7:0] last_q = 8'h00;
    logic dev_drv;
    logic [7:0] dev_data;
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 8'hff;
            need[i] = 1;
            hits[i] = 0;
        end
    end
    always @(mem_addr or host_data or host_oe or chip_on_n or output_drv_n
             or vpp_raise) begin
        t_chg = $time;
    end
    always @(negedge prog_strobe_n) begin
        if (vpp_raise && !chip_on_n && ($time - t_chg < 2000))
            violations++;
        t_fall = $time;
    end
    // Zeros only: no electrical path back to one
    always @(posedge prog_strobe_n) begin
        if (vpp_raise && !chip_on_n
            && output_drv_n) begin
            pulses++;
            width_ns = $time - t_fall;
            hits[mem_addr]++;
            if (hits[mem_addr] >= need[mem_addr])
                mem[mem_addr] &= byte_lines;
        end
    end
    // ****************************************
    // Read, verify and identifier output
    // ****************************************
    assign dev_drv = !chip_on_n && !output_drv_n
        && prog_strobe_n;
    assign dev_data = id_hv_on ? (mem_addr[0] ? PART_CODE : MAKER_CODE)
                               : mem[mem_addr];
    // Undriven line shows a changing pattern, not the old byte
    assign byte_lines = host_oe ? host_data : (dev_drv ? dev_data : ~last_q);
    always @(posedge clk) begin
        last_q <= byte_lines;
        if (host_oe && dev_drv)
            violations++;
        if (dev_drv && id_hv_on && ((mem_addr & 14'h3dfe) != 14'h0000))
            violations++;
    end
endmodule : mem_device_model
`default_nettype wire

// *** verif/eprom_host_tb.sv ***
// Self-checking bench for the memory programmer and reader
`timescale 1ns/1ps
`default_nettype none
module eprom_host_tb;
    localparam int PULSES = 50;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] PART = 8'h1e; // Arbitrary value
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    eprom_host_pkg::op_type cmd_op = eprom_host_pkg::OP_READ;
    logic [13:0] cmd_addr = 14'h0000;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, resp_valid, resp_fail, device_failed;
    logic chip_on_n, output_drv_n, prog_strobe_n, vpp_raise, id_hv_on;
    logic byte_lines_oe;
    logic [7:0] resp_data, byte_lines_out, byte_lines;
    logic [13:0] mem_addr;
    logic [7:0] rd;
    logic fl;
    int miscompares = 0;
    int compares = 0;
    int p0;
    always #5 clk = ~clk;
    eprom_host #(.PULSE_CYCLES(PULSES)) dut (.clk(clk), .reset(reset),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_fail(resp_fail),
        .device_failed(device_failed), .mem_addr(mem_addr),
        .chip_on_n(chip_on_n), .output_drv_n(output_drv_n),
        .prog_strobe_n(prog_strobe_n), .vpp_raise(vpp_raise),
        .id_hv_on(id_hv_on), .byte_lines_in(byte_lines),
        .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe));
    mem_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) mem (
        .clk(clk), .mem_addr(mem_addr), .chip_on_n(chip_on_n),
        .output_drv_n(output_drv_n), .prog_strobe_n(prog_strobe_n),
        .vpp_raise(vpp_raise), .id_hv_on(id_hv_on),
        .host_data(byte_lines_out), .host_oe(byte_lines_oe),
        .byte_lines(byte_lines));
    // ****************************************
    // Shared tasks
    // ****************************************
    task close_out;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task check(input logic [15:0] got, input logic [15:0] exp,
               input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : check
    task run(input eprom_host_pkg::op_type op, input logic [13:0] a,
             input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20000) begin
            miscompares++;
            $display("CHECK FAILED at %0t: no answer", $time);
            close_out();
        end else begin
            rd = resp_data;
            fl = resp_fail;
        end
    endtask : run
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        check(chip_on_n, 1'b1, "standby");
        check({output_drv_n, prog_strobe_n}, 16'h3, "inhibit");
        check({vpp_raise, id_hv_on, byte_lines_oe}, 16'h0, "off");
        check(cmd_ready, 1'b1, "ready");
        $display("test reset done");
    endtask : t_reset
    task t_erased;
        run(eprom_host_pkg::OP_READ, 14'h0000, 8'h00);
        check(rd, 8'hff, "erased low");
        run(eprom_host_pkg::OP_READ, 14'h3fff, 8'h00);
        check(rd, 8'hff, "erased top");
        $display("test erased done");
    endtask : t_erased
    task t_prog_once;
        p0 = mem.pulses;
        run(eprom_host_pkg::OP_PROGRAM, 14'h1234, 8'ha5);
        check(fl, 1'b0, "program pass");
        check(rd, 8'ha5, "verify byte");
        check(mem.pulses - p0, 1, "one pulse");
        check(mem.width_ns, PULSES * 10, "pulse width");
        run(eprom_host_pkg::OP_READ, 14'h1234, 8'h00);
        check(rd, 8'ha5, "read back");
        run(eprom_host_pkg::OP_READ, 14'h1235, 8'h00);
        check(rd, 8'hff, "neighbour");
        $display("test program once done");
    endtask : t_prog_once
    task t_prog_retry;
        mem.need[2] = 3;
        p0 = mem.pulses;
        run(eprom_host_pkg::OP_PROGRAM, 14'h0002, 8'h3c);
        check(fl, 1'b0, "retry pass");
        check(mem.pulses - p0, 3, "three pulses");
        $display("test program retry done");
    endtask : t_prog_retry
    task t_signature;
        run(eprom_host_pkg::OP_SIGNATURE, 14'h0000, 8'h00);
        check(rd, MAKER, "maker code");
        run(eprom_host_pkg::OP_SIGNATURE, 14'h0001, 8'h00);
        check(rd, PART, "part code");
        $display("test signature done");
    endtask : t_signature
    task t_check;
        p0 = mem.pulses;
        run(eprom_host_pkg::OP_CHECK, 14'h1234, 8'ha5);
        check(fl, 1'b0, "check match");
        run(eprom_host_pkg::OP_CHECK, 14'h1234, 8'h00);
        check(fl, 1'b1, "check mismatch");
        check(mem.pulses - p0, 0, "no pulses");
        $display("test check done");
    endtask : t_check
    task t_fail;
        p0 = mem.pulses;
        run(eprom_host_pkg::OP_PROGRAM, 14'h1234, 8'hff);
        check(fl, 1'b1, "ones refused");
        check(mem.pulses - p0, 10, "ten pulses");
        check(rd, 8'ha5, "byte kept");
        check(device_failed, 1'b1, "failed flag");
        p0 = mem.pulses;
        run(eprom_host_pkg::OP_PROGRAM, 14'h0005, 8'h00);
        check(fl, 1'b1, "program blocked");
        check(mem.pulses - p0, 0, "blocked pulses");
        run(eprom_host_pkg::OP_READ, 14'h0005, 8'h00);
        check(rd, 8'hff, "blocked byte");
        $display("test failure done");
    endtask : t_fail
    initial begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        t_reset();
        t_erased();
        t_prog_once();
        t_prog_retry();
        t_signature();
        t_check();
        t_fail();
        check(mem.violations, 0, "pins");
        close_out();
    end
endmodule : eprom_host_tb
`default_nettype wire
